// ===== inc/seq_pkg.sv
// Constants, register map and types for the converter power sequencer.
package seq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int RAMP_TIME_US = 4000;
  localparam int RAMP_CYCLES = RAMP_TIME_US * CLK_KHZ / 1000;
  localparam int SENSE_TIME_US = 100;
  localparam int SENSE_CYCLES = SENSE_TIME_US * CLK_KHZ / 1000;
  localparam int RAMP_STEPS = 1024;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_REF_LO = 8'h00;
  localparam logic [7:0] REG_REF_HI = 8'h01;
  localparam logic [7:0] REG_MODE = 8'h06;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // Mode register fields.
  localparam int MODE_OE = 7;
  localparam int MODE_DISCHARGE = 4;
  localparam int MODE_VCC_EXT = 2;
  localparam int MODE_ADDR_HI = 1;
  localparam int MODE_PFM = 0;

  // Status register fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_VCC_VIN = 3;
  localparam int STAT_RAMP_DONE = 4;
  localparam int STAT_STRAP_DONE = 5;
  localparam int STAT_DISCHARGE = 6;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int REF_W = 10;
  localparam logic [REF_W-1:0] REF_RESET = 10'h000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [6:0] BUS_ADDR_LO = 7'h74;
  localparam logic [6:0] BUS_ADDR_HI = 7'h75;
  localparam int SYNC_W = 14;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_STANDBY = 3'b001,
    ST_READY = 3'b010,
    ST_RAMP = 3'b011,
    ST_RUN = 3'b100
  } seq_state_t;

endpackage

// ===== core/sync_stage.sv
// Two-flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// ===== core/power_sequencer.sv
// Buck-boost converter control sequencer with APB register access.
//
// Contract
// - Pick bias supply from input/output comparators.
// - Decode strap into bias, address, light-load mode.
// - Bus writes override strap settings once enabled.
// - Input lockout below 2.6 V, release above 3 V.
// - Enable pin mid-band: standby, sense and latch strap.
// - Above 1.23 V: bus and switching permitted.
// - Hysteresis current on while pin above threshold.
// - Output enable ramps reference over 4 ms.
// - Below 0.4 V: shutdown, registers to defaults.
// - Output enable low stops switching, bus stays.
// - Discharge while stopped until output below 0.8 V.
// - Reference from 10-bit value across two registers.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module power_sequencer
  import seq_pkg::*;
#(
  parameter int RAMP_LEN = seq_pkg::RAMP_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator results
  input wire logic vin_above_3v0,
  input wire logic vin_below_2v6,
  input wire logic en_above_0v4,
  input wire logic en_above_1v15,
  input wire logic en_above_1v23,
  input wire logic vin_gt_vout,
  input wire logic vin_above_6v2,
  input wire logic vin_below_5v9,
  input wire logic vout_above_6v2,
  input wire logic vout_below_5v9,
  input wire logic vout_above_0v8,
  // Strap resistor detector code
  input wire logic [2:0] strap_code,
  // Converter controls
  output logic vcc_from_vin,
  output logic vcc_external,
  output logic [6:0] bus_address,
  output logic pulse_skip_light_load,
  output logic bus_enable,
  output logic switching_enable,
  output logic hyst_current_on,
  output logic discharge_on,
  output logic [9:0] ref_code
);
  import seq_pkg::*;

  localparam int STEP_LEN = (RAMP_LEN / RAMP_STEPS < 1) ? 1 : RAMP_LEN / RAMP_STEPS;
  localparam int SENSE_LEN = (SENSE_CYCLES < 1) ? 1 : SENSE_CYCLES;

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // Returns mode register bits for a strap code: bit 2 external bias,
  // bit 1 upper bus address, bit 0 pulse-skip at light load.
  function automatic logic [7:0] strap_to_mode(input logic [2:0] code);
    logic [7:0] m;
    m = MODE_RESET;
    m[MODE_VCC_EXT] = code[2];
    m[MODE_ADDR_HI] = code[1];
    m[MODE_PFM] = code[0];
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_q;
  logic s_vin_3v0, s_vin_2v6, s_en_0v4, s_en_1v15, s_en_1v23;
  logic s_vin_gt, s_vin_6v2, s_vin_5v9, s_vout_6v2, s_vout_5v9;
  logic s_vout_0v8;
  logic [2:0] s_strap;

  sync_stage #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({strap_code, vout_above_0v8, vout_below_5v9, vout_above_6v2,
               vin_below_5v9, vin_above_6v2, vin_gt_vout, en_above_1v23,
               en_above_1v15, en_above_0v4, vin_below_2v6, vin_above_3v0}),
    .sync_out(sync_q)
  );

  assign {s_strap, s_vout_0v8, s_vout_5v9, s_vout_6v2, s_vin_5v9, s_vin_6v2,
          s_vin_gt, s_en_1v23, s_en_1v15, s_en_0v4, s_vin_2v6, s_vin_3v0} = sync_q;

  // ----------------------------------------------------------------
  // Input lockout
  // ----------------------------------------------------------------
  logic input_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_ok <= 1'b0;
    end else if (s_vin_2v6) begin
      input_ok <= 1'b0;
    end else if (s_vin_3v0) begin
      input_ok <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bias supply selection
  // ----------------------------------------------------------------
  // Between the two thresholds the previous choice is held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcc_from_vin <= 1'b1;
    end else if (!s_vin_gt) begin
      if (s_vin_6v2) begin
        vcc_from_vin <= 1'b1;
      end else if (s_vin_5v9) begin
        vcc_from_vin <= 1'b0;
      end
    end else begin
      if (s_vout_6v2) begin
        vcc_from_vin <= 1'b0;
      end else if (s_vout_5v9) begin
        vcc_from_vin <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  logic shutdown;
  logic strap_done;
  logic sense_hit;
  logic ramp_done;
  logic [15:0] sense_cnt;
  logic [7:0] mode_reg;
  logic [REF_W-1:0] ref_target;

  assign shutdown = !s_en_0v4;
  assign sense_hit = (sense_cnt == 16'(SENSE_LEN - 1));

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (input_ok && s_en_1v15) begin
          next_state = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (strap_done && s_en_1v23) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (mode_reg[MODE_OE]) begin
          next_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (!mode_reg[MODE_OE]) begin
          next_state = ST_READY;
        end else if (ramp_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!mode_reg[MODE_OE]) begin
          next_state = ST_READY;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (!input_ok || !s_en_1v15 || shutdown) begin
      next_state = ST_OFF;
    end else if (!s_en_1v23 && state != ST_OFF) begin
      next_state = ST_STANDBY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Strap sensing in standby
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_cnt <= '0;
      strap_done <= 1'b0;
    end else if (shutdown) begin
      sense_cnt <= '0;
      strap_done <= 1'b0;
    end else if (state == ST_STANDBY && !strap_done) begin
      if (sense_hit) begin
        strap_done <= 1'b1;
      end
      sense_cnt <= sense_hit ? '0 : sense_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic access;
  logic mapped;
  logic wr_ok;
  logic [7:0] reg_idx;
  logic [31:0] read_word;

  assign reg_idx = paddr[9:2];
  assign access = psel && penable && pready;
  assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                  (reg_idx == REG_REF_LO || reg_idx == REG_REF_HI ||
                   reg_idx == REG_MODE || reg_idx == REG_STATUS);
  // Registers are reachable only while the bus is enabled.
  assign wr_ok = access && pwrite && mapped && bus_enable;

  always_comb begin
    read_word = 32'h0000_0000;
    case (reg_idx)
      REG_REF_LO: read_word[7:0] = ref_target[7:0];
      REG_REF_HI: read_word[1:0] = ref_target[9:8];
      REG_MODE: read_word[7:0] = mode_reg;
      REG_STATUS: begin
        read_word[STAT_STATE_LSB +: 3] = state;
        read_word[STAT_VCC_VIN] = vcc_from_vin;
        read_word[STAT_RAMP_DONE] = (state == ST_RUN);
        read_word[STAT_STRAP_DONE] = strap_done;
        read_word[STAT_DISCHARGE] = discharge_on;
      end
      default: read_word = 32'h0000_0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped || !bus_enable;
      prdata <= (mapped && bus_enable && !pwrite) ? read_word : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_RESET;
      ref_target <= REF_RESET;
    end else if (shutdown) begin
      mode_reg <= MODE_RESET;
      ref_target <= REF_RESET;
    end else if (state == ST_STANDBY && !strap_done && sense_hit) begin
      mode_reg <= strap_to_mode(s_strap);
    end else if (wr_ok) begin
      case (reg_idx)
        REG_REF_LO: ref_target[7:0] <= pwdata[7:0];
        REG_REF_HI: ref_target[9:8] <= pwdata[1:0];
        REG_MODE: mode_reg <= pwdata[7:0];
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcc_external <= 1'b0;
      bus_address <= BUS_ADDR_LO;
      pulse_skip_light_load <= 1'b0;
    end else begin
      vcc_external <= mode_reg[MODE_VCC_EXT];
      bus_address <= mode_reg[MODE_ADDR_HI] ? BUS_ADDR_HI : BUS_ADDR_LO;
      pulse_skip_light_load <= mode_reg[MODE_PFM];
    end
  end

  // ----------------------------------------------------------------
  // Reference soft-start ramp
  // ----------------------------------------------------------------
  logic [15:0] step_cnt;
  logic step_tick;
  logic [10:0] ramp_pos;
  logic [20:0] scaled;

  assign step_tick = (step_cnt == 16'(STEP_LEN - 1));
  assign ramp_done = (ramp_pos == 11'(RAMP_STEPS));
  assign scaled = 21'(ref_target) * 21'(ramp_pos);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt <= '0;
      ramp_pos <= '0;
    end else if (state != ST_RAMP && state != ST_RUN) begin
      step_cnt <= '0;
      ramp_pos <= '0;
    end else if (!ramp_done) begin
      step_cnt <= step_tick ? '0 : step_cnt + 16'h0001;
      if (step_tick) begin
        ramp_pos <= ramp_pos + 11'h001;
      end
    end
  end

  // The reference tracks the target directly once the ramp is done.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_code <= '0;
    end else if (state == ST_RUN) begin
      ref_code <= ref_target;
    end else if (state == ST_RAMP) begin
      ref_code <= scaled[19:10];
    end else begin
      ref_code <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Converter enables
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_enable <= 1'b0;
      switching_enable <= 1'b0;
      hyst_current_on <= 1'b0;
      discharge_on <= 1'b0;
    end else begin
      bus_enable <= (next_state == ST_READY || next_state == ST_RAMP ||
                     next_state == ST_RUN);
      switching_enable <= (next_state == ST_RAMP || next_state == ST_RUN);
      hyst_current_on <= s_en_1v23 && !shutdown;
      discharge_on <= (next_state == ST_READY) && mode_reg[MODE_DISCHARGE] &&
                      s_vout_0v8;
    end
  end

endmodule
`default_nettype wire

// ===== tb/apb_host.sv
// Bus controller model that issues APB register transfers.
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // Issues one transfer: setup cycle, access until pready, then returns prdata and pslverr.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== tb/power_sequencer_monitor.sv
// Concurrent checks on the power sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module power_sequencer_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Comparators
  input wire logic vin_below_2v6,
  input wire logic en_above_0v4,
  input wire logic en_above_1v23,
  input wire logic vout_above_0v8,
  // Controls
  input wire logic bus_enable,
  input wire logic switching_enable,
  input wire logic hyst_current_on,
  input wire logic discharge_on,
  input wire logic [9:0] ref_code
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready timing wrong");
  idle_refuse_a: assert property (psel && penable && !pready && !bus_enable |=> pslverr)
    else $error("pslverr missing");
  lockout_off_a: assert property (vin_below_2v6 [*5] |-> !bus_enable && !switching_enable)
    else $error("active in lockout");
  shutdown_clear_a: assert property (!en_above_0v4 [*4] |-> ref_code == 10'h000 && !bus_enable)
    else $error("active in shutdown");
  low_pin_a: assert property (!en_above_1v23 [*4] |-> !switching_enable && !hyst_current_on)
    else $error("on below threshold");
  hyst_on_a: assert property ((en_above_1v23 && en_above_0v4) [*4] |-> hyst_current_on)
    else $error("hysteresis off");
  sink_stop_a: assert property (discharge_on |-> !switching_enable)
    else $error("sink while switching");
  sink_end_a: assert property (!vout_above_0v8 [*4] |-> !discharge_on)
    else $error("sink below level");
  ramp_zero_a: assert property ($rose(switching_enable) |-> ref_code == 10'h000)
    else $error("ramp not from zero");
  ramp_up_a: assert property (switching_enable && $past(switching_enable) |-> ref_code >= $past(ref_code))
    else $error("ramp fell");
endmodule

bind power_sequencer power_sequencer_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .vin_below_2v6(vin_below_2v6),
  .en_above_0v4(en_above_0v4), .en_above_1v23(en_above_1v23), .vout_above_0v8(vout_above_0v8),
  .bus_enable(bus_enable), .switching_enable(switching_enable),
  .hyst_current_on(hyst_current_on), .discharge_on(discharge_on), .ref_code(ref_code));
`default_nettype wire

// ===== tb/power_sequencer_bench.sv
// Self-checking bench for the power sequencer.
`timescale 1ns/1ps
`default_nettype none
module power_sequencer_bench;
  import seq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic vin_above_3v0, vin_below_2v6, en_above_0v4, en_above_1v15, en_above_1v23;
  logic vin_gt_vout, vin_above_6v2, vin_below_5v9, vout_above_6v2, vout_below_5v9;
  logic vout_above_0v8, vcc_from_vin, vcc_external, pulse_skip_light_load;
  logic bus_enable, switching_enable, hyst_current_on, discharge_on;
  logic [2:0] strap_code;
  logic [6:0] bus_address;
  logic [9:0] ref_code;
  int error_cnt = 0;
  int compares = 0;

  // ----------------------------------------------------------------
  // Instances and helpers
  // ----------------------------------------------------------------
  power_sequencer #(.RAMP_LEN(1024)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vin_above_3v0(vin_above_3v0),
    .vin_below_2v6(vin_below_2v6), .en_above_0v4(en_above_0v4),
    .en_above_1v15(en_above_1v15), .en_above_1v23(en_above_1v23), .vin_gt_vout(vin_gt_vout),
    .vin_above_6v2(vin_above_6v2), .vin_below_5v9(vin_below_5v9),
    .vout_above_6v2(vout_above_6v2), .vout_below_5v9(vout_below_5v9),
    .vout_above_0v8(vout_above_0v8), .strap_code(strap_code), .vcc_from_vin(vcc_from_vin),
    .vcc_external(vcc_external), .bus_address(bus_address),
    .pulse_skip_light_load(pulse_skip_light_load), .bus_enable(bus_enable),
    .switching_enable(switching_enable), .hyst_current_on(hyst_current_on),
    .discharge_on(discharge_on), .ref_code(ref_code));
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d, rd, err);
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp,
                       input logic exp_err);
    host.xfer(1'b0, idx, 32'h0, rd, err);
    check(name, rd, exp);
    check("bus_err", 32'(err), 32'(exp_err));
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic power_cycle(input logic [2:0] c);
    @(posedge pclk);
    en_above_0v4 <= 1'b0;
    en_above_1v15 <= 1'b0;
    en_above_1v23 <= 1'b0;
    tick(6);
    check("off_bus", 32'(bus_enable), 32'h0);
    @(posedge pclk);
    strap_code <= c;
    vin_above_3v0 <= 1'b1;
    en_above_0v4 <= 1'b1;
    en_above_1v15 <= 1'b1;
    tick(1010);
    check("standby_bus", 32'(bus_enable), 32'h0);
    check("standby_hyst", 32'(hyst_current_on), 32'h0);
    check("strap_ext", 32'(vcc_external), 32'(c[2]));
    check("strap_addr", 32'(bus_address), 32'(c[1] ? BUS_ADDR_HI : BUS_ADDR_LO));
    check("strap_skip", 32'(pulse_skip_light_load), 32'(c[0]));
    rdchk("standby_rd", REG_REF_LO, 32'h0, 1'b1);
    en_above_1v23 <= 1'b1;
    tick(5);
    check("run_bus", 32'(bus_enable), 32'h1);
    check("run_hyst", 32'(hyst_current_on), 32'h1);
  endtask

  task automatic bias(input logic [4:0] v, input logic exp);
    @(posedge pclk);
    {vin_gt_vout, vin_above_6v2, vin_below_5v9, vout_above_6v2, vout_below_5v9} <= v;
    tick(5);
    check("bias_src", 32'(vcc_from_vin), 32'(exp));
  endtask

  task automatic override_check();
    wr(REG_MODE, 32'h01);
    tick(2);
    check("ovr_ext", 32'(vcc_external), 32'h0);
    check("ovr_addr", 32'(bus_address), 32'(BUS_ADDR_LO));
    check("ovr_skip", 32'(pulse_skip_light_load), 32'h1);
  endtask

  task automatic ramp_check();
    wr(REG_REF_LO, 32'h34);
    wr(REG_REF_HI, 32'h2);
    rdchk("ref_lo", REG_REF_LO, 32'h34, 1'b0);
    rdchk("ref_hi", REG_REF_HI, 32'h2, 1'b0);
    wr(REG_MODE, 32'h80);
    tick(3);
    check("ramp_on", 32'(switching_enable), 32'h1);
    check("ramp_mid", 32'(ref_code < 10'h234), 32'h1);
    tick(1100);
    check("ramp_end", 32'(ref_code), 32'h234);
    host.xfer(1'b0, REG_STATUS, 32'h0, rd, err);
    check("run_state", 32'(rd[2:0]), 32'(ST_RUN));
  endtask

  task automatic stop_check();
    wr(REG_MODE, 32'h10);
    tick(4);
    check("stop_sw", 32'(switching_enable), 32'h0);
    check("sink_on", 32'(discharge_on), 32'h1);
    rdchk("stop_rd", REG_MODE, 32'h10, 1'b0);
    rdchk("unmapped", 8'h03, 32'h0, 1'b1);
    vout_above_0v8 <= 1'b0;
    tick(5);
    check("sink_off", 32'(discharge_on), 32'h0);
  endtask

  task automatic clear_check();
    power_cycle(3'h0);
    rdchk("clr_ref", REG_REF_HI, 32'h0, 1'b0);
    rdchk("clr_mode", REG_MODE, 32'h0, 1'b0);
  endtask

  task automatic lockout_check();
    @(posedge pclk);
    vin_above_3v0 <= 1'b0;
    vin_below_2v6 <= 1'b1;
    tick(5);
    check("lock_bus", 32'(bus_enable), 32'h0);
    check("lock_sw", 32'(switching_enable), 32'h0);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #5000000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    {vin_above_3v0, vin_below_2v6, en_above_0v4, en_above_1v15, en_above_1v23} = 5'h00;
    {vin_gt_vout, vin_above_6v2, vin_below_5v9, vout_above_6v2, vout_below_5v9} = 5'h00;
    vout_above_0v8 = 1'b1;
    strap_code = 3'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      power_cycle(3'(c));
    end
    override_check();
    ramp_check();
    stop_check();
    clear_check();
    bias(5'b00100, 1'b0);
    bias(5'b01000, 1'b1);
    bias(5'b10010, 1'b0);
    bias(5'b10001, 1'b1);
    lockout_check();
    wrap_up();
  end
endmodule
`default_nettype wire
